/* rtl/uiec_defines.svh */
// Offsets, field positions, reset values and counts of the IN endpoint control block
// Notes on behaviour
// R01: Bulk/interrupt mode: every NAK answered to an IN token sets a sticky underrun flag.
// R02: FIFO-has-packet bit reads 0 when empty, 1 when one or more packets wait.
// R03: Firmware sets packet-ready only after the packet is fully loaded.
// R04: Hardware clears packet-ready once the packet has gone to the host.
// R05: Double buffering with a free slot: hardware clears packet-ready for the next load.
// R06: Isochronous with SOF-synced release: packet-ready reads 0 until the next SOF.
// R07: Clearing packet-ready on transmission raises the endpoint interrupt when enabled.
// R08: High control bit 7 enables double buffering.
// R09: High control bit 6 selects isochronous (1) or bulk/interrupt (0).
// R10: Direction bit 5 counts only while unsplit; 1 means IN, 0 OUT.
// R11: Force-toggle 0: data toggle advances only on host acknowledgement.
// R12: Force-toggle 1: data toggle advances after every transmitted packet.
// R13: Split bit 2 gives the upper FIFO half to IN, lower half to OUT.
// R14: High control bits 4 and 1:0 read zero, writes ignored.
// R15: Flush discards next packet, resets pointer, clears packet-ready, then self-clears.
// R16: Toggle-clear write resets the data toggle to 0 and reads back 0.
// R17: All high control bits reset to zero.
`ifndef UIEC_DEFINES_SVH
`define UIEC_DEFINES_SVH

// Register offsets
`define UIEC_OFS_CTRL_LOW   8'h11
`define UIEC_OFS_CTRL_HIGH  8'h12
`define UIEC_OFS_OPTIONS    8'h13
`define UIEC_OFS_INT_STATUS 8'h20
`define UIEC_OFS_INT_CLEAR  8'h21
`define UIEC_OFS_INT_ENABLE 8'h22
`define UIEC_OFS_FIFO_STATE 8'h23

// Low control fields
`define UIEC_BIT_READY      0
`define UIEC_BIT_HAS_PKT    1
`define UIEC_BIT_UNDERRUN   2
`define UIEC_BIT_FLUSH      3
`define UIEC_BIT_TOG_CLEAR  6

// High control fields
`define UIEC_BIT_DBUF       7
`define UIEC_BIT_ISO        6
`define UIEC_BIT_DIR        5
`define UIEC_BIT_FORCE_TOG  3
`define UIEC_BIT_SPLIT      2
`define UIEC_HIGH_MASK      8'hec
`define UIEC_HIGH_RESET     8'h00

// Options and interrupt fields
`define UIEC_BIT_SOF_SYNC   0
`define UIEC_INT_TX_DONE    0
`define UIEC_INT_UNDERRUN   1

// Slot counts
`define UIEC_SLOTS_SINGLE   2'h1
`define UIEC_SLOTS_DOUBLE   2'h2

`endif

/* rtl/uiec_pkg.sv */
// Types shared by the IN endpoint control block
package uiec_pkg;

  // Link answer sequencer
  typedef enum logic [0:0] {
    UIEC_LINK_IDLE,
    UIEC_LINK_SENDING
  } uiec_link_e;

  // Register state of the controller
  typedef struct packed {
    uiec_link_e  link;
    logic        ready;
    logic        iso_hold;
    logic        underrun;
    logic        flush;
    logic        toggle;
    logic [7:0]  ctrl_high;
    logic        sof_sync;
    logic [1:0]  int_status;
    logic [1:0]  int_enable;
    logic        send_data;
    logic        send_nak;
    logic        ptr_reset;
    logic [7:0]  rdata;
  } uiec_state_s;

  // Register state of the slot tracker
  typedef struct packed {
    logic [1:0]  count;
  } uiec_slot_s;

  typedef logic [1:0] uiec_count_t;

endpackage

/* rtl/uiec_slot_if.sv */
// Carrier between the controller and its packet slot tracker
`timescale 1ns/1ps
`default_nettype none
interface uiec_slot_if;
  logic               load;
  logic               unload;
  logic               double_buf;
  uiec_pkg::uiec_count_t count;
  logic               has_packet;
  logic               slot_free;

  modport tracker (input load, input unload, input double_buf,
                   output count, output has_packet, output slot_free);
  modport ctrl    (output load, output unload, output double_buf,
                   input count, input has_packet, input slot_free);
endinterface
`default_nettype wire

/* rtl/uiec_slot_tracker.sv */
// Counts packets held in the IN endpoint FIFO
`timescale 1ns/1ps
`default_nettype none
`include "uiec_defines.svh"
module uiec_slot_tracker (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Controller side
  uiec_slot_if.tracker slots
);
  import uiec_pkg::*;

  uiec_slot_s state;
  uiec_slot_s next_state;
  uiec_count_t limit;

  // Capacity follows the double-buffer setting
  assign limit = slots.double_buf ? `UIEC_SLOTS_DOUBLE : `UIEC_SLOTS_SINGLE;

  // Load and unload in one cycle cancel; underflow saturates so a flush on empty is harmless
  always_comb begin
    next_state = state;
    if (slots.load && !slots.unload && state.count < limit) begin
      next_state.count = state.count + 2'h1;
    end else if (slots.unload && !slots.load && state.count != 2'h0) begin
      next_state.count = state.count - 2'h1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Status back to the controller
  assign slots.count      = state.count;
  assign slots.has_packet = (state.count != 2'h0); // [R02]
  assign slots.slot_free  = (state.count < limit);
endmodule
`default_nettype wire

/* rtl/uiec_top.sv */
// IN endpoint control and status: registers, packet-ready handshake, link answers, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "uiec_defines.svh"
module uiec_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Serial engine events
  input  wire logic       in_token,
  input  wire logic       sof_token,
  input  wire logic       tx_done,
  input  wire logic       host_ack,
  // Serial engine answers
  output logic            send_data,
  output logic            send_nak,
  output logic            data_toggle,
  // FIFO steering
  output logic            fifo_ptr_reset,
  output logic            fifo_split,
  output logic            endpoint_is_in,
  // Interrupt
  output logic            irq
);
  import uiec_pkg::*;

  uiec_state_s state;
  uiec_state_s next_state;
  uiec_slot_if slots ();

  // Decoded strobes
  logic wr_low;
  logic wr_high;
  logic wr_opt;
  logic wr_clear;
  logic wr_enable;
  logic fw_ready_set;
  logic tx_finish;
  logic in_accept;
  logic in_refuse;
  logic iso_mode;
  logic dbuf_mode;
  logic [7:0] low_view;

  // Register write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs, input logic stb);
    hit = stb && (addr == ofs);
  endfunction

  // Packet slot tracker
  uiec_slot_tracker u_slots (
    .clk   (clk),
    .srst  (srst),
    .slots (slots.tracker)
  );

  assign wr_low    = hit(reg_addr, `UIEC_OFS_CTRL_LOW, reg_wr);
  assign wr_high   = hit(reg_addr, `UIEC_OFS_CTRL_HIGH, reg_wr);
  assign wr_opt    = hit(reg_addr, `UIEC_OFS_OPTIONS, reg_wr);
  assign wr_clear  = hit(reg_addr, `UIEC_OFS_INT_CLEAR, reg_wr);
  assign wr_enable = hit(reg_addr, `UIEC_OFS_INT_ENABLE, reg_wr);

  // Mode bits
  assign dbuf_mode = state.ctrl_high[`UIEC_BIT_DBUF]; // [R08]
  assign iso_mode  = state.ctrl_high[`UIEC_BIT_ISO];  // [R09]

  // Firmware commits a loaded packet; a commit with no free slot is dropped
  assign fw_ready_set = wr_low && reg_wdata[`UIEC_BIT_READY] && !state.ready; // [R03]

  // The serial engine reports the packet on the wire is finished
  assign tx_finish = (state.link == UIEC_LINK_SENDING) && tx_done;

  // An IN token finds a packet only when one is held and not withheld for the frame
  assign in_accept = (state.link == UIEC_LINK_IDLE) && in_token && slots.has_packet && !state.iso_hold;
  assign in_refuse = (state.link == UIEC_LINK_IDLE) && in_token && !in_accept;

  // Slot bookkeeping
  assign slots.double_buf = dbuf_mode;
  assign slots.load       = fw_ready_set && slots.slot_free;
  assign slots.unload     = tx_finish || state.flush; // [R04] [R15]

  // Readback view of the low control byte
  always_comb begin
    low_view                      = 8'h00;
    low_view[`UIEC_BIT_READY]     = state.ready && !state.iso_hold; // [R06]
    low_view[`UIEC_BIT_HAS_PKT]   = slots.has_packet;               // [R02]
    low_view[`UIEC_BIT_UNDERRUN]  = state.underrun;
    low_view[`UIEC_BIT_FLUSH]     = state.flush;
    low_view[`UIEC_BIT_TOG_CLEAR] = 1'b0;                           // [R16]
  end

  // Next-state logic for the whole controller
  always_comb begin
    next_state           = state;
    next_state.send_data = 1'b0;
    next_state.send_nak  = 1'b0;
    next_state.ptr_reset = 1'b0;

    // Configuration writes; unused high bits are masked away
    if (wr_high) begin
      next_state.ctrl_high = reg_wdata & `UIEC_HIGH_MASK; // [R14]
    end
    if (wr_opt) begin
      next_state.sof_sync = reg_wdata[`UIEC_BIT_SOF_SYNC];
    end
    if (wr_enable) begin
      next_state.int_enable = reg_wdata[1:0];
    end

    // Underrun flag: firmware clears by writing 0, a new NAK in the same cycle wins
    if (wr_low && !reg_wdata[`UIEC_BIT_UNDERRUN]) begin
      next_state.underrun = 1'b0;
    end

    // Packet commit from firmware
    if (slots.load) begin
      if (dbuf_mode && slots.count == 2'h0) begin
        next_state.ready = 1'b0; // [R05]
      end else begin
        next_state.ready = 1'b1;
      end
      if (iso_mode && state.sof_sync) begin
        next_state.iso_hold = 1'b1; // [R06]
      end
    end

    // The frame start releases a withheld isochronous packet
    if (sof_token) begin
      next_state.iso_hold = 1'b0; // [R06]
    end

    // Flush request: one packet discarded on the following cycle
    if (state.flush) begin
      next_state.flush     = 1'b0; // [R15]
      next_state.ready     = 1'b0; // [R15]
      next_state.ptr_reset = 1'b1; // [R15]
    end
    // A new request wins over the self-clear, so back-to-back flushes each discard a packet
    if (wr_low && reg_wdata[`UIEC_BIT_FLUSH]) begin
      next_state.flush = 1'b1; // [R15]
    end

    // Toggle-clear is an action, not a stored bit
    if (wr_low && reg_wdata[`UIEC_BIT_TOG_CLEAR]) begin
      next_state.toggle = 1'b0; // [R16]
    end

    // Link answer sequencer
    case (state.link)
      UIEC_LINK_IDLE: begin
        if (in_accept) begin
          next_state.send_data = 1'b1;
          next_state.link      = UIEC_LINK_SENDING;
        end else if (in_refuse) begin
          next_state.send_nak = 1'b1;
          if (!iso_mode) begin
            next_state.underrun                     = 1'b1; // [R01]
            next_state.int_status[`UIEC_INT_UNDERRUN] = 1'b1;
          end
        end
      end
      UIEC_LINK_SENDING: begin
        if (tx_done) begin
          next_state.link = UIEC_LINK_IDLE;
          // Ready always drops on a sent packet; with double buffering a slot is now free
          next_state.ready = 1'b0; // [R04] [R05]
          next_state.int_status[`UIEC_INT_TX_DONE] = 1'b1; // [R07]
          if (state.ctrl_high[`UIEC_BIT_FORCE_TOG]) begin
            next_state.toggle = ~state.toggle; // [R12]
          end else if (host_ack) begin
            next_state.toggle = ~state.toggle; // [R11]
          end
        end
      end
      default: begin
        next_state.link = UIEC_LINK_IDLE;
      end
    endcase

    // Interrupt status: write-one-to-clear, a new event in the same cycle wins
    if (wr_clear) begin
      next_state.int_status = next_state.int_status & ~reg_wdata[1:0];
      if (tx_finish) begin
        next_state.int_status[`UIEC_INT_TX_DONE] = 1'b1;
      end
      if (in_refuse && !iso_mode) begin
        next_state.int_status[`UIEC_INT_UNDERRUN] = 1'b1;
      end
    end

    // Read data stand one cycle after the strobe and only then
    next_state.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `UIEC_OFS_CTRL_LOW:   next_state.rdata = low_view;
        `UIEC_OFS_CTRL_HIGH:  next_state.rdata = state.ctrl_high & `UIEC_HIGH_MASK; // [R14]
        `UIEC_OFS_OPTIONS:    next_state.rdata = {7'h00, state.sof_sync};
        `UIEC_OFS_INT_STATUS: next_state.rdata = {6'h00, state.int_status};
        `UIEC_OFS_INT_ENABLE: next_state.rdata = {6'h00, state.int_enable};
        `UIEC_OFS_FIFO_STATE: next_state.rdata = {4'h0, state.toggle, state.link == UIEC_LINK_SENDING, slots.count};
        default:              next_state.rdata = 8'h00;
      endcase
    end
  end

  // State register; every control bit clears on reset
  always_ff @(posedge clk) begin
    if (srst) begin
      state           <= '0;
      state.link      <= UIEC_LINK_IDLE;
      state.ctrl_high <= `UIEC_HIGH_RESET; // [R17]
    end else begin
      state <= next_state;
    end
  end

  // Outputs
  assign reg_rdata      = state.rdata;
  assign send_data      = state.send_data;
  assign send_nak       = state.send_nak;
  assign data_toggle    = state.toggle;
  assign fifo_ptr_reset = state.ptr_reset;
  assign fifo_split     = state.ctrl_high[`UIEC_BIT_SPLIT]; // [R13]
  // A split FIFO always serves IN on its upper half, so direction only matters unsplit
  assign endpoint_is_in = state.ctrl_high[`UIEC_BIT_SPLIT] | state.ctrl_high[`UIEC_BIT_DIR]; // [R10]
  assign irq            = |(state.int_status & state.int_enable); // [R07]
endmodule
`default_nettype wire

/* sim/uiec_chk.sv */
// Concurrent checks on the IN endpoint control ports
`timescale 1ns/1ps
`default_nettype none
module uiec_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Link events and answers
  input wire logic       in_token,
  input wire logic       sof_token,
  input wire logic       tx_done,
  input wire logic       host_ack,
  input wire logic       send_data,
  input wire logic       send_nak,
  input wire logic       data_toggle,
  // Steering and interrupt
  input wire logic       fifo_ptr_reset,
  input wire logic       fifo_split,
  input wire logic       endpoint_is_in,
  input wire logic       irq
);
  logic [7:0] high;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Shadow of the high control byte, so reads and steering can be judged
  always_ff @(posedge clk) begin
    if (srst) begin
      high <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h12) begin
      high <= reg_wdata;
    end
  end
  AST_RESET_QUIET: assert property ($fell(srst) |-> !reg_rdata && !irq && !data_toggle && !endpoint_is_in)
    else $error("outputs not quiet after reset");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_ONE_ANSWER: assert property (!(send_data && send_nak))
    else $error("data and nak together");
  AST_ANSWER_CAUSE: assert property ((send_data || send_nak) |-> $past(in_token))
    else $error("answer without token");
  AST_HIGH_READ: assert property ($past(reg_rd) && $past(reg_addr) == 8'h12 |-> reg_rdata == ($past(high) & 8'hec))
    else $error("high control read wrong");
  AST_SPLIT: assert property (fifo_split == high[2])
    else $error("split output wrong");
  AST_DIR: assert property (endpoint_is_in == (high[2] | high[5]))
    else $error("direction output wrong");
  AST_TOGGLE: assert property ($past(tx_done) && !$past(reg_wr) |->
    data_toggle == ($past(data_toggle) ^ ($past(host_ack) | $past(high[3]))))
    else $error("data toggle step wrong");
  AST_FLUSH: assert property (reg_wr && reg_addr == 8'h11 && reg_wdata[3] |-> ##[1:3] fifo_ptr_reset)
    else $error("flush gave no pointer reset");
  AST_IRQ_HOLD: assert property (irq && !(reg_wr && (reg_addr == 8'h21 || reg_addr == 8'h22)) |=> irq)
    else $error("interrupt dropped without clear");
  // Main scenarios reached
  cover property (send_data);
  cover property (send_nak);
  cover property ($rose(irq));
endmodule
bind uiec_top uiec_chk uiec_chk_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_token(in_token), .sof_token(sof_token),
  .tx_done(tx_done), .host_ack(host_ack), .send_data(send_data), .send_nak(send_nak),
  .data_toggle(data_toggle), .fifo_ptr_reset(fifo_ptr_reset), .fifo_split(fifo_split),
  .endpoint_is_in(endpoint_is_in), .irq(irq));
`default_nettype wire

/* sim/uiec_host_model.sv */
// Serial engine stand-in: issues IN and SOF tokens and ends data packets
`timescale 1ns/1ps
`default_nettype none
module uiec_host_model (
  // Clock
  input  wire logic clk,
  // Answers from the endpoint
  input  wire logic send_data,
  input  wire logic send_nak,
  // Events toward the endpoint
  output var logic  in_token,
  output var logic  sof_token,
  output var logic  tx_done,
  output var logic  host_ack
);
  // Idle levels; ack starts high and after each packet idles at the opposite of its ack, so a stray sample outside tx_done shows up
  initial begin
    in_token = 1'b0;
    sof_token = 1'b0;
    tx_done = 1'b0;
    host_ack = 1'b1;
  end
  // One IN transaction; gap stretches the packet to model a slow link
  task automatic xfer(input logic ack, input int gap, output logic got, output logic nak);
    @(posedge clk);
    in_token <= 1'b1;
    @(posedge clk);
    in_token <= 1'b0;
    #1;
    got = send_data;
    nak = send_nak;
    if (got) begin
      repeat (gap) @(posedge clk);
      @(posedge clk);
      tx_done <= 1'b1;
      host_ack <= ack;
      @(posedge clk);
      tx_done <= 1'b0;
      host_ack <= ~ack;
    end
  endtask
  // Start-of-frame pulse
  task automatic sof();
    @(posedge clk);
    sof_token <= 1'b1;
    @(posedge clk);
    sof_token <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/uiec_test.sv */
// Self-checking bench for the IN endpoint control block
`timescale 1ns/1ps
`default_nettype none
module uiec_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        in_token, sof_token, tx_done, host_ack, send_data, send_nak, data_toggle;
  logic        fifo_ptr_reset, fifo_split, endpoint_is_in, irq, got, nak;
  logic [31:0] seed = 32'hc4ff;
  logic [7:0]  tbl [4] = '{8'hff, 8'h20, 8'h04, 8'h00};
  logic [7:0]  m_high;
  logic        m_tog = 1'b0;
  int          q [$];
  int          fails = 0, comparisons = 0, cycles = 0;
  uiec_top uiec_top_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_token(in_token), .sof_token(sof_token), .tx_done(tx_done),
    .host_ack(host_ack), .send_data(send_data), .send_nak(send_nak), .data_toggle(data_toggle),
    .fifo_ptr_reset(fifo_ptr_reset), .fifo_split(fifo_split), .endpoint_is_in(endpoint_is_in), .irq(irq));
  uiec_host_model uiec_host_model_i (.clk(clk), .send_data(send_data), .send_nak(send_nak),
    .in_token(in_token), .sof_token(sof_token), .tx_done(tx_done), .host_ack(host_ack));
  // 200 MHz clock; a hung run is cut short well past the expected length
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Low control byte expected from the reference queue
  function automatic logic [7:0] low(input logic rdy, input logic und);
    return {5'h00, und, q.size() > 0, rdy};
  endfunction
  task automatic close_out();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rdc(8'h12, 8'h00);
    rdc(8'h11, low(0, 0));
    // Random bytes first, then corner patterns ending unsplit and idle
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      m_high = (i < 8) ? seed[7:0] : tbl[i-8];
      wr(8'h12, m_high);
      m_high &= 8'hec;
      rdc(8'h12, m_high);
      chk({fifo_split, endpoint_is_in}, {m_high[2], m_high[2] | m_high[5]});
    end
    wr(8'h22, 8'h03);
    uiec_host_model_i.xfer(1'b1, 0, got, nak);
    chk({got, nak}, 8'h01);
    rdc(8'h11, low(0, 1));
    rdc(8'h20, 8'h02);
    wr(8'h21, 8'h03);
    wr(8'h11, 8'h00);
    rdc(8'h11, low(0, 0));
    // Each force and acknowledge mix, prompt with force off and slow with force on
    for (int f = 0; f < 2; f++) begin
      for (int a = 0; a < 2; a++) begin
        wr(8'h12, 8'(f << 3));
        wr(8'h11, 8'h01);
        q.push_back(a);
        rdc(8'h11, low(1, 0));
        uiec_host_model_i.xfer(1'(a), f * 3, got, nak);
        chk({got, nak}, 8'h02);
        void'(q.pop_front());
        m_tog ^= 1'(a | f);
        repeat (2) @(posedge clk);
        #1 chk(data_toggle, m_tog);
        rdc(8'h11, low(0, 0));
        rdc(8'h20, 8'h01);
        chk(irq, 1'b1);
        wr(8'h21, 8'h01);
        #1 chk(irq, 1'b0);
      end
    end
    wr(8'h11, 8'h40);
    @(posedge clk);
    #1 chk(data_toggle, 1'b0);
    rdc(8'h11, low(0, 0));
    wr(8'h11, 8'h01);
    wr(8'h11, 8'h08);
    @(posedge clk);
    #1 chk(fifo_ptr_reset, 1'b1);
    rdc(8'h11, low(0, 0));
    // Double buffering frees the slot at once; a second packet fills both slots
    wr(8'h12, 8'h80);
    wr(8'h11, 8'h01);
    q.push_back(1);
    rdc(8'h11, low(0, 0));
    wr(8'h11, 8'h01);
    q.push_back(1);
    rdc(8'h11, low(1, 0));
    for (int p = 0; p < 2; p++) begin
      uiec_host_model_i.xfer(1'b1, 0, got, nak);
      chk({got, nak}, 8'h02);
      void'(q.pop_front());
      rdc(8'h11, low(0, 0));
    end
    // Isochronous with release held back to the next frame
    wr(8'h12, 8'h40);
    wr(8'h13, 8'h01);
    wr(8'h11, 8'h01);
    q.push_back(1);
    rdc(8'h11, low(0, 0));
    uiec_host_model_i.xfer(1'b1, 0, got, nak);
    chk({got, nak}, 8'h01);
    rdc(8'h11, low(0, 0));
    uiec_host_model_i.sof();
    uiec_host_model_i.xfer(1'b1, 0, got, nak);
    chk({got, nak}, 8'h02);
    void'(q.pop_front());
    rdc(8'h11, low(0, 0));
    // Reset in mid-run returns every control bit, flag and toggle to zero
    chk(irq, 1'b1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk({irq, data_toggle, fifo_split, endpoint_is_in}, 8'h00);
    rdc(8'h12, 8'h00);
    rdc(8'h13, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
